// >>> logic/ppc_register_bank.sv
// Purpose: control and status register bank of the programmable logic peripheral
// Assumes: host strobes synchronous to clk_sys_in; pin inputs asynchronous
// Notes:   power registers clear only on power_up_in, not on reset_in
// How it works
// - output-enable status bits read one per pin driver enabled
// - input-cell register returns the eight input cells in bits 7..0
// - writing group A register loads its output flip-flops; reading returns them
// - writing group B register loads its output flip-flops; reading returns them
// - a set group A mask bit keeps that flip-flop from host writes
// - a set group B mask bit keeps that flip-flop from host writes
// - main flash lock register shows one write-protect bit per sector
// - boot flash lock bits 3..0 show secondary sector write protection
// - boot flash bit 7 shows the read-out lock, bits 6..4 zero
// - debug register bit 0 enables the serial test port
// - page register drives the array page inputs and resets to zero
// - power registers clear only at power-up, not on the reset pin
// - power reg 0 bit 1 enables automatic power-down
// - power reg 0 bit 3 set turns full-speed mode off
// - power reg 0 bit 4 cuts clock from AND array; while it is clear and bit 3 is set, clock edges wake
// - power reg 0 bit 5 cuts clock from output cells
// - power reg 1 bit 0 blocks low address byte from the array
// - wide-bus mode takes address 3..0 from port F, 7..4 from muxed pins
// - power reg 1 bits 2..4 cut control pins 0..2 from the array
// - power reg 1 bit 5 cuts the address latch strobe from the array
// - power reg 1 bit 6 cuts the high-byte write strobe from the array
//
// The strobed register port and the register addresses were chosen for this implementation.
module ppc_register_bank #(
  parameter int N_MAIN_SECTORS = 8,
  parameter int N_BOOT_SECTORS = 4
) (
  input  wire logic                      clk_sys_in,
  input  wire logic                      reset_in,
  input  wire logic                      power_up_in,
  input  wire ppc_pkg::ppc_bus_req_t     bus_in,
  output logic [7:0]                     rdata_out,
  input  wire logic [7:0]                driver_enable_in,
  input  wire logic [7:0]                input_cells_in,
  input  wire logic [7:0]                main_sector_lock_in,
  input  wire logic [3:0]                boot_sector_lock_in,
  input  wire logic                      readout_lock_in,
  input  wire logic                      wide_bus_cpu_mode_in,
  input  wire logic [7:0]                host_addr_low_in,
  input  wire logic [3:0]                port_f_low_pins_in,
  input  wire logic [3:0]                upper_muxed_addr_data_pins_in,
  input  wire logic [2:0]                control_pins_in,
  input  wire logic                      ale_in,
  input  wire logic                      high_byte_write_strobe_in,
  input  wire logic                      logic_clock_input_in,
  output logic [7:0]                     output_cells_group_a_out,
  output logic [7:0]                     output_cells_group_b_out,
  output logic                           debug_port_enable_bit_out,
  output logic [7:0]                     page_bits_out,
  output logic                           auto_power_down_out,
  output logic                           logic_full_speed_out,
  output ppc_pkg::ppc_array_in_t         array_in_out
);
  // the readback packing below only serves eight main and four boot sectors
  if (N_MAIN_SECTORS != 8 || N_BOOT_SECTORS != 4) begin : g_bad_sectors
    $error("sector counts must be 8 and 4");
  end

  // two-flop synchronisers for all pin inputs
  logic [7:0]  s1_drv, s2_drv, s1_imc, s2_imc, s1_main, s2_main, s1_addr, s2_addr;
  logic [3:0]  s1_boot, s2_boot, s1_pf, s2_pf, s1_ad, s2_ad;
  logic [2:0]  s1_ctl, s2_ctl;
  logic [4:0]  s1_misc, s2_misc;

  always_ff @(posedge clk_sys_in) begin
    s1_drv  <= driver_enable_in;
    s2_drv  <= s1_drv;
    s1_imc  <= input_cells_in;
    s2_imc  <= s1_imc;
    s1_main <= main_sector_lock_in;
    s2_main <= s1_main;
    s1_addr <= host_addr_low_in;
    s2_addr <= s1_addr;
    s1_boot <= boot_sector_lock_in;
    s2_boot <= s1_boot;
    s1_pf   <= port_f_low_pins_in;
    s2_pf   <= s1_pf;
    s1_ad   <= upper_muxed_addr_data_pins_in;
    s2_ad   <= s1_ad;
    s1_ctl  <= control_pins_in;
    s2_ctl  <= s1_ctl;
    s1_misc <= {readout_lock_in, wide_bus_cpu_mode_in, ale_in, high_byte_write_strobe_in, logic_clock_input_in};
    s2_misc <= s1_misc;
  end

  logic readout_lock, wide_mode, ale_s, wrh_s, clk_s;
  assign readout_lock = s2_misc[4];
  assign wide_mode    = s2_misc[3];
  assign ale_s        = s2_misc[2];
  assign wrh_s        = s2_misc[1];
  assign clk_s        = s2_misc[0];

  // masked load: mask bit 1 holds the old value
  function automatic logic [7:0] masked_load(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic [7:0] mask);
    masked_load = (old_v & mask) | (new_v & ~mask);
  endfunction

  function automatic logic hit(input ppc_pkg::ppc_bus_req_t r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  ppc_pkg::ppc_state_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.clk_in_q = clk_s;
    if (hit(bus_in, ppc_pkg::OFS_CELL_A))
      nxt_st.output_cells_group_a = masked_load(st_ff.output_cells_group_a, bus_in.wdata, st_ff.mask_a);
    if (hit(bus_in, ppc_pkg::OFS_CELL_B))
      nxt_st.output_cells_group_b = masked_load(st_ff.output_cells_group_b, bus_in.wdata, st_ff.mask_b);
    if (hit(bus_in, ppc_pkg::OFS_MASK_A))
      nxt_st.mask_a = bus_in.wdata;
    if (hit(bus_in, ppc_pkg::OFS_MASK_B))
      nxt_st.mask_b = bus_in.wdata;
    if (hit(bus_in, ppc_pkg::OFS_DEBUG_EN))
      nxt_st.debug_en = bus_in.wdata & ppc_pkg::DEBUG_MASK;
    if (hit(bus_in, ppc_pkg::OFS_PAGE))
      nxt_st.page_bits = bus_in.wdata;
    if (hit(bus_in, ppc_pkg::OFS_PWR_0))
      nxt_st.pwr0 = bus_in.wdata & ppc_pkg::PWR0_MASK;
    if (hit(bus_in, ppc_pkg::OFS_PWR_1))
      nxt_st.pwr1 = bus_in.wdata & ppc_pkg::PWR1_MASK;

    // read data valid the cycle after the strobe only
    nxt_st.rdata = ppc_pkg::RST_BYTE;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        ppc_pkg::OFS_OE_STATUS:  nxt_st.rdata = s2_drv;
        ppc_pkg::OFS_IN_CELLS:   nxt_st.rdata = s2_imc;
        ppc_pkg::OFS_CELL_A:     nxt_st.rdata = st_ff.output_cells_group_a;
        ppc_pkg::OFS_CELL_B:     nxt_st.rdata = st_ff.output_cells_group_b;
        ppc_pkg::OFS_MASK_A:     nxt_st.rdata = st_ff.mask_a;
        ppc_pkg::OFS_MASK_B:     nxt_st.rdata = st_ff.mask_b;
        ppc_pkg::OFS_MAIN_LOCK:  nxt_st.rdata = s2_main;
        ppc_pkg::OFS_BOOT_LOCK:  nxt_st.rdata = {readout_lock, 3'h0, s2_boot};
        ppc_pkg::OFS_DEBUG_EN:   nxt_st.rdata = st_ff.debug_en;
        ppc_pkg::OFS_PAGE:       nxt_st.rdata = st_ff.page_bits;
        ppc_pkg::OFS_PWR_0:      nxt_st.rdata = st_ff.pwr0;
        ppc_pkg::OFS_PWR_1:      nxt_st.rdata = st_ff.pwr1;
        default:                 nxt_st.rdata = ppc_pkg::RST_BYTE;
      endcase
    end

    // power regs survive reset_in; cleared only by power-up
    if (power_up_in) begin
      nxt_st.pwr0 = ppc_pkg::RST_BYTE;
      nxt_st.pwr1 = ppc_pkg::RST_BYTE;
      nxt_st.pwr_init_done = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || power_up_in) begin
      st_ff.output_cells_group_a <= ppc_pkg::RST_BYTE;
      st_ff.output_cells_group_b <= ppc_pkg::RST_BYTE;
      st_ff.mask_a               <= ppc_pkg::RST_BYTE;
      st_ff.mask_b               <= ppc_pkg::RST_BYTE;
      st_ff.debug_en             <= ppc_pkg::RST_BYTE;
      st_ff.page_bits            <= ppc_pkg::RST_BYTE;
      st_ff.rdata                <= ppc_pkg::RST_BYTE;
      st_ff.clk_in_q             <= 1'b0;
      st_ff.pwr0                 <= nxt_st.pwr0;
      st_ff.pwr1                 <= nxt_st.pwr1;
      st_ff.pwr_init_done        <= nxt_st.pwr_init_done;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_out                 = st_ff.rdata;
  assign output_cells_group_a_out  = st_ff.output_cells_group_a;
  assign output_cells_group_b_out  = st_ff.output_cells_group_b;
  assign debug_port_enable_bit_out = st_ff.debug_en[0];
  assign page_bits_out             = st_ff.page_bits;
  assign auto_power_down_out       = st_ff.pwr0[ppc_pkg::PWR0_APD_BIT];
  assign logic_full_speed_out      = ~st_ff.pwr0[ppc_pkg::PWR0_SLOW_BIT];

  logic [7:0] array_addr;
  assign array_addr = wide_mode ? {s2_ad, s2_pf} : s2_addr;

  always_comb begin
    array_in_out = '0;
    array_in_out.addr = st_ff.pwr1[ppc_pkg::PWR1_ADDR_BIT] ? 8'h00 : array_addr;
    for (int i = 0; i < 3; i++)
      array_in_out.control_pins[i] = s2_ctl[i] & ~st_ff.pwr1[ppc_pkg::PWR1_CONTROL_PIN_0_BIT + i];
    array_in_out.ale = ale_s & ~st_ff.pwr1[ppc_pkg::PWR1_ALE_BIT];
    array_in_out.high_byte_write_strobe = wrh_s & ~st_ff.pwr1[ppc_pkg::PWR1_WRH_BIT];
    array_in_out.clk_and_array = clk_s & ~st_ff.pwr0[ppc_pkg::PWR0_ACLK_BIT];
    array_in_out.clk_out_cells = clk_s & ~st_ff.pwr0[ppc_pkg::PWR0_MCLK_BIT];
    // wake pulse: clock edge reaches array while full speed is off
    array_in_out.wake = (clk_s ^ st_ff.clk_in_q) & ~st_ff.pwr0[ppc_pkg::PWR0_ACLK_BIT]
                        & st_ff.pwr0[ppc_pkg::PWR0_SLOW_BIT];
  end

  a_mask_holds_a: assert property (@(posedge clk_sys_in) disable iff (reset_in || power_up_in)
    hit(bus_in, ppc_pkg::OFS_CELL_A) |=> ((output_cells_group_a_out & $past(st_ff.mask_a))
      == ($past(output_cells_group_a_out) & $past(st_ff.mask_a))))
    else $error("masked group a bit changed");
  a_mask_holds_b: assert property (@(posedge clk_sys_in) disable iff (reset_in || power_up_in)
    hit(bus_in, ppc_pkg::OFS_CELL_B) |=> ((output_cells_group_b_out & $past(st_ff.mask_b))
      == ($past(output_cells_group_b_out) & $past(st_ff.mask_b))))
    else $error("masked group b bit changed");
  a_load_cell_a: assert property (@(posedge clk_sys_in) disable iff (reset_in || power_up_in)
    hit(bus_in, ppc_pkg::OFS_CELL_A) |=> ((output_cells_group_a_out & ~$past(st_ff.mask_a))
      == ($past(bus_in.wdata) & ~$past(st_ff.mask_a))))
    else $error("group a not loaded");
  a_load_cell_b: assert property (@(posedge clk_sys_in) disable iff (reset_in || power_up_in)
    hit(bus_in, ppc_pkg::OFS_CELL_B) |=> ((output_cells_group_b_out & ~$past(st_ff.mask_b))
      == ($past(bus_in.wdata) & ~$past(st_ff.mask_b))))
    else $error("group b not loaded");
  a_pwr_keeps_reset: assert property (@(posedge clk_sys_in) disable iff (power_up_in)
    (reset_in && !bus_in.wr) |=> (st_ff.pwr0 == $past(st_ff.pwr0) && st_ff.pwr1 == $past(st_ff.pwr1)))
    else $error("power register lost on reset pin");
  a_page_reset: assert property (@(posedge clk_sys_in)
    reset_in |=> page_bits_out == 8'h00)
    else $error("page not cleared");
  a_boot_read: assert property (@(posedge clk_sys_in) disable iff (reset_in || power_up_in)
    (bus_in.rd && bus_in.addr == ppc_pkg::OFS_BOOT_LOCK) |=> (rdata_out[6:4] == 3'h0
      && rdata_out[ppc_pkg::BOOT_SEC_BIT] == $past(readout_lock)))
    else $error("boot lock readback wrong");
  a_addr_block: assert property (@(posedge clk_sys_in) disable iff (reset_in || power_up_in)
    st_ff.pwr1[ppc_pkg::PWR1_ADDR_BIT] |-> array_in_out.addr == 8'h00)
    else $error("address not blocked");
  a_ro_write: assert property (@(posedge clk_sys_in) disable iff (reset_in || power_up_in)
    (bus_in.wr && bus_in.addr == ppc_pkg::OFS_PWR_0) |=> (st_ff.pwr0 & ~ppc_pkg::PWR0_MASK) == 8'h00)
    else $error("unused power bit set");
endmodule

// >>> include/ppc_pkg.sv
// Purpose: shared constants and carriers for the port control register bank
// Assumes: 8-bit host data bus, byte offsets as printed in the register map
// Notes:   offsets are byte addresses of an 8-bit bus
package ppc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] OFS_IN_CELLS   = 8'h0A;
  localparam logic [7:0] OFS_OE_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_CELL_A     = 8'h20;
  localparam logic [7:0] OFS_CELL_B     = 8'h21;
  localparam logic [7:0] OFS_MASK_A     = 8'h22;
  localparam logic [7:0] OFS_MASK_B     = 8'h23;
  localparam logic [7:0] OFS_PWR_0      = 8'hB0;
  localparam logic [7:0] OFS_PWR_1      = 8'hB4;
  localparam logic [7:0] OFS_MAIN_LOCK  = 8'hC0;
  localparam logic [7:0] OFS_BOOT_LOCK  = 8'hC2;
  localparam logic [7:0] OFS_DEBUG_EN   = 8'hC7;
  localparam logic [7:0] OFS_PAGE       = 8'hE0;

  localparam logic [7:0] RST_BYTE       = 8'h00;

  // writable bits of the power and debug control registers
  localparam logic [7:0] PWR0_MASK      = 8'h3A;
  localparam logic [7:0] PWR1_MASK      = 8'h7D;
  localparam logic [7:0] DEBUG_MASK     = 8'h01;

  localparam int PWR0_APD_BIT   = 1;
  localparam int PWR0_SLOW_BIT  = 3;
  localparam int PWR0_ACLK_BIT  = 4;
  localparam int PWR0_MCLK_BIT  = 5;
  localparam int PWR1_ADDR_BIT  = 0;
  localparam int PWR1_CONTROL_PIN_0_BIT = 2;
  localparam int PWR1_ALE_BIT   = 5;
  localparam int PWR1_WRH_BIT   = 6;
  localparam int BOOT_SEC_BIT   = 7;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ppc_bus_req_t;

  // gated inputs presented to the logic array
  typedef struct packed {
    logic [7:0] addr;
    logic [2:0] control_pins;
    logic       ale;
    logic       high_byte_write_strobe;
    logic       clk_and_array;
    logic       clk_out_cells;
    logic       wake;
  } ppc_array_in_t;

  typedef struct packed {
    logic [7:0] output_cells_group_a;
    logic [7:0] output_cells_group_b;
    logic [7:0] mask_a;
    logic [7:0] mask_b;
    logic [7:0] debug_en;
    logic [7:0] page_bits;
    logic [7:0] pwr0;
    logic [7:0] pwr1;
    logic       pwr_init_done;
    logic [7:0] rdata;
    logic       clk_in_q;
  } ppc_state_t;
endpackage

// >>> verification/ppc_host_model.sv
// Purpose: host bus master that issues single-byte register cycles
// Assumes: slave never stalls; read data stands only in the cycle after rd
// Notes:   tasks are called from the bench by hierarchical name
module ppc_host_model (
  input  wire logic                  clk_sys_in,
  output ppc_pkg::ppc_bus_req_t      bus_out,
  input  wire logic [7:0]            rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial bus_out = '0;

  // #1 lets the taking edge's updates land before the caller looks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in) bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in) bus_out.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in) bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in) bus_out.rd <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule

// >>> verification/tb_top.sv
// Purpose: self-checking bench for the port control register bank
// Assumes: status and pin inputs settle through two sync flops
// Notes:   random pins and register values, seed fixed
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic power_up_in = 1'b1;
  ppc_pkg::ppc_bus_req_t bus;
  ppc_pkg::ppc_array_in_t arr;
  logic [7:0] rdata, oc_a, oc_b, page, v, m, d, p0, p1, ma, mb;
  logic [7:0] drv_en = '0, in_cells = '0, main_lock = '0, host_addr = '0;
  logic [3:0] boot_lock = '0, pf_low = '0, upper = '0;
  logic [2:0] ctl = '0;
  logic ro_lock = 1'b0, wide = 1'b0, ale = 1'b0, wrh = 1'b0, lclk = 1'b0;
  logic dbg, auto_power_down, fs;
  int n_errors = 0;
  int tests_run = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  ppc_host_model host (.clk_sys_in(clk_sys_in), .bus_out(bus), .rdata_in(rdata));

  ppc_register_bank dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .power_up_in(power_up_in),
    .bus_in(bus), .rdata_out(rdata), .driver_enable_in(drv_en), .input_cells_in(in_cells),
    .main_sector_lock_in(main_lock), .boot_sector_lock_in(boot_lock), .readout_lock_in(ro_lock),
    .wide_bus_cpu_mode_in(wide), .host_addr_low_in(host_addr), .port_f_low_pins_in(pf_low),
    .upper_muxed_addr_data_pins_in(upper), .control_pins_in(ctl), .ale_in(ale),
    .high_byte_write_strobe_in(wrh), .logic_clock_input_in(lclk), .output_cells_group_a_out(oc_a),
    .output_cells_group_b_out(oc_b), .debug_port_enable_bit_out(dbg), .page_bits_out(page),
    .auto_power_down_out(auto_power_down), .logic_full_speed_out(fs), .array_in_out(arr));

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      n_errors++;
    end
  endtask

  function automatic logic [7:0] masked(input logic [7:0] old, input logic [7:0] dat, input logic [7:0] msk);
    return (old & msk) | (dat & ~msk);
  endfunction

  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic pulse(input bit pin);
    @(posedge clk_sys_in) if (pin) reset_in <= 1'b1; else power_up_in <= 1'b1;
    @(posedge clk_sys_in) begin
      reset_in <= 1'b0;
      power_up_in <= 1'b0;
    end
  endtask

  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end

  initial begin
    logic [7:0] ofs [8];
    ofs = '{ppc_pkg::OFS_CELL_A, ppc_pkg::OFS_CELL_B, ppc_pkg::OFS_MASK_A, ppc_pkg::OFS_MASK_B,
            ppc_pkg::OFS_PWR_0, ppc_pkg::OFS_PWR_1, ppc_pkg::OFS_DEBUG_EN, ppc_pkg::OFS_PAGE};
    v = 8'($urandom(67));
    repeat (12) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    power_up_in <= 1'b0;
    foreach (ofs[i]) begin
      host.rd(ofs[i], v);
      chk("reset value", v, 8'h00);
    end
    chk("page out at reset", page, 8'h00);
    ma = '0;
    mb = '0;
    for (int i = 0; i < 16; i++) begin
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      d = 8'($urandom);
      host.wr(ppc_pkg::OFS_MASK_A, m);
      host.wr(ppc_pkg::OFS_MASK_B, ~m);
      host.wr(ppc_pkg::OFS_CELL_A, d);
      host.wr(ppc_pkg::OFS_CELL_B, ~d);
      ma = masked(ma, d, m);
      mb = masked(mb, ~d, ~m);
      chk("cells a out", oc_a, ma);
      chk("cells b out", oc_b, mb);
      host.rd(ppc_pkg::OFS_CELL_A, v);
      chk("cells a read", v, ma);
      host.rd(ppc_pkg::OFS_CELL_B, v);
      chk("cells b read", v, mb);
    end
    host.wr(ppc_pkg::OFS_DEBUG_EN, 8'hFF);
    host.rd(ppc_pkg::OFS_DEBUG_EN, v);
    chk("debug read", v, 8'h01);
    chk("debug out", 8'(dbg), 8'h01);
    d = 8'($urandom);
    host.wr(ppc_pkg::OFS_PAGE, d);
    chk("page out", page, d);
    host.wr(ppc_pkg::OFS_PWR_0, 8'h02);
    chk("auto power down", 8'(auto_power_down), 8'h01);
    chk("full speed on", 8'(fs), 8'h01);
    host.wr(ppc_pkg::OFS_PWR_0, 8'hFF);
    host.wr(ppc_pkg::OFS_PWR_1, 8'hFF);
    chk("full speed off", 8'(fs), 8'h00);
    // pin reset must spare power regs but clear the page
    pulse(1'b1);
    host.rd(ppc_pkg::OFS_PWR_0, v);
    chk("pwr0 after pin reset", v, 8'h3A);
    host.rd(ppc_pkg::OFS_PWR_1, v);
    chk("pwr1 after pin reset", v, 8'h7D);
    chk("page after pin reset", page, 8'h00);
    pulse(1'b0);
    host.rd(ppc_pkg::OFS_PWR_0, v);
    chk("pwr0 after power-up", v, 8'h00);
    host.rd(ppc_pkg::OFS_PWR_1, v);
    chk("pwr1 after power-up", v, 8'h00);
    for (int i = 0; i < 12; i++) begin
      p0 = 8'($urandom) & ppc_pkg::PWR0_MASK;
      p1 = 8'($urandom) & ppc_pkg::PWR1_MASK;
      host.wr(ppc_pkg::OFS_PWR_0, p0);
      host.wr(ppc_pkg::OFS_PWR_1, p1);
      @(posedge clk_sys_in) begin
        drv_en <= 8'($urandom);
        in_cells <= 8'($urandom);
        main_lock <= 8'($urandom);
        boot_lock <= 4'($urandom);
        ro_lock <= 1'($urandom);
        wide <= 1'($urandom);
        host_addr <= 8'($urandom);
        pf_low <= 4'($urandom);
        upper <= 4'($urandom);
        ctl <= 3'($urandom);
        ale <= 1'($urandom);
        wrh <= 1'($urandom);
        lclk <= 1'($urandom);
      end
      // two sync flops plus margin
      repeat (4) @(posedge clk_sys_in);
      #1;
      chk("array addr", arr.addr, p1[0] ? 8'h00 : wide ? {upper, pf_low} : host_addr);
      chk("array cntl", 8'(arr.control_pins), 8'(ctl & ~p1[4:2]));
      chk("array ale", 8'(arr.ale), 8'(ale & ~p1[5]));
      chk("array wrh", 8'(arr.high_byte_write_strobe), 8'(wrh & ~p1[6]));
      chk("array clk", 8'(arr.clk_and_array), 8'(lclk & ~p0[4]));
      chk("cells clk", 8'(arr.clk_out_cells), 8'(lclk & ~p0[5]));
      chk("wake idle", 8'(arr.wake), 8'h00);
      @(posedge clk_sys_in) lclk <= ~lclk;
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk("wake pulse", 8'(arr.wake), 8'(p0[3] & ~p0[4]));
      @(posedge clk_sys_in);
      #1;
      chk("wake ends", 8'(arr.wake), 8'h00);
      host.wr(ppc_pkg::OFS_MAIN_LOCK, ~main_lock);
      host.wr(ppc_pkg::OFS_OE_STATUS, ~drv_en);
      host.rd(ppc_pkg::OFS_OE_STATUS, v);
      chk("oe status", v, drv_en);
      host.rd(ppc_pkg::OFS_IN_CELLS, v);
      chk("input cells", v, in_cells);
      host.rd(ppc_pkg::OFS_MAIN_LOCK, v);
      chk("main lock", v, main_lock);
      host.rd(ppc_pkg::OFS_BOOT_LOCK, v);
      chk("boot lock", v, {ro_lock, 3'b000, boot_lock});
      host.rd(8'h55, v);
      chk("unmapped read", v, 8'h00);
    end
    print_verdict();
  end
endmodule
